// file: rtl/cho_option_upper.sv
// Notes on behaviour
// R1: bit 7 picks performance (0) or low power (1); resets to 1.
// R2: low power and battery only turns off gate drive supply and ADC.
// R3: bits 6-5 pick watchdog: off, 5s, 88s, 175s; resets to 11.
// R4: an expired watchdog forces the charge current setting to zero.
// R5: host writes to charge current restart the watchdog count.
// R6: bit 4 (reset 0) turns input current loop off on cell removal.
// R7: bit 3 at 0 holds good indicator high in reverse mode.
// R8: bit 1 picks 1200/800kHz, reset 1; bit 2 keeps PFM above 25kHz.
// R9: bit 0 enables low-ripple pass-through; resets to 1.
// R10: option byte sits at address 0x01, reset value 0xe7.
// R11: charge current setting sits at addresses 0x02 and 0x03.
// R12: all eight option bits read back the last written value.
module cho_option_upper
    import cho_pkg::*;
#(
    parameter longint WDT_SHORT_CYC =
        cho_pkg::CHO_WDT_SHORT_S * cho_pkg::CHO_CLK_HZ,
    parameter longint WDT_MID_CYC =
        cho_pkg::CHO_WDT_MID_S * cho_pkg::CHO_CLK_HZ,
    parameter longint WDT_LONG_CYC =
        cho_pkg::CHO_WDT_LONG_S * cho_pkg::CHO_CLK_HZ
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic battery_only_pin,
    input wire logic cell_removed_pin,
    input wire logic reverse_mode_pin,
    input wire logic power_good_raw_pin,
    output logic low_power_active,
    output logic gate_drive_supply_off,
    output logic adc_off,
    output logic input_current_loop_off,
    output logic power_good_indicator,
    output logic ultrasonic_pfm_enable,
    output logic switching_frequency_select,
    output logic passthrough_low_ripple,
    output logic [6:0] charge_current_setting,
    output logic watchdog_expired
);
    // **************************************************
    // state
    // **************************************************
    logic [3:0] sync1_reg, sync1_next;
    logic [3:0] sync2_reg, sync2_next;
    logic [7:0] option_reg, option_next;
    logic [6:0] current_reg, current_next;
    logic [7:0] rdata_reg, rdata_next;
    logic lp_reg, lp_next;
    logic loop_off_reg, loop_off_next;
    logic good_reg, good_next;
    logic expired_reg, expired_next;
    logic wr_option, wr_cur_low, wr_cur_high, cur_write, wdt_expire;
    logic batt_only_s, cell_removed_s, reverse_s, good_raw_s;

    assign batt_only_s = sync2_reg[0];
    assign cell_removed_s = sync2_reg[1];
    assign reverse_s = sync2_reg[2];
    assign good_raw_s = sync2_reg[3];

    // **************************************************
    // register decode
    // **************************************************
    assign wr_option = reg_wr && reg_addr == CHO_ADDR_OPTION_UPPER; // R10
    assign wr_cur_low = reg_wr && reg_addr == CHO_ADDR_CURRENT_LOW; // R11
    assign wr_cur_high = reg_wr && reg_addr == CHO_ADDR_CURRENT_HIGH; // R11
    assign cur_write = wr_cur_low || wr_cur_high;

    cho_watchdog #(
        .SHORT_CYC(WDT_SHORT_CYC),
        .MID_CYC(WDT_MID_CYC),
        .LONG_CYC(WDT_LONG_CYC)
    ) u_watchdog (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .timeout_select(cho_timeout_t'(
            option_reg[CHO_BIT_TIMEOUT_HI:CHO_BIT_TIMEOUT_LO])), // R3
        .restart(cur_write), // R5
        .expire(wdt_expire)
    );

    // **************************************************
    // next-state logic
    // **************************************************
    always_comb begin
        // pin levels pass two flops before anything looks at them
        sync1_next = {power_good_raw_pin, reverse_mode_pin,
                      cell_removed_pin, battery_only_pin};
        sync2_next = sync1_reg;

        option_next = option_reg;
        if (wr_option) begin
            option_next = reg_wdata; // R12
        end

        // a host write in the expiry cycle wins over the clear
        current_next = current_reg;
        if (wdt_expire && !cur_write) begin
            current_next = CHO_CURRENT_RESET; // R4
        end
        if (wr_cur_high) begin
            current_next[6:2] = reg_wdata[CHO_CUR_HIGH_MSB:0]; // R11
        end
        if (wr_cur_low) begin
            current_next[1:0] = reg_wdata[7:CHO_CUR_LOW_LSB]; // R11
        end

        rdata_next = rdata_reg;
        if (reg_rd) begin
            unique case (reg_addr)
                CHO_ADDR_OPTION_UPPER: rdata_next = option_reg; // R12
                CHO_ADDR_CURRENT_HIGH: rdata_next = {3'h0, current_reg[6:2]};
                CHO_ADDR_CURRENT_LOW: rdata_next = {current_reg[1:0], 6'h00};
                default: rdata_next = 8'h00;
            endcase
        end

        lp_next = option_reg[CHO_BIT_LOW_POWER] && batt_only_s; // R2
        loop_off_next = option_reg[CHO_BIT_LOOP_AUTO_OFF]
            && cell_removed_s; // R6
        // with the indicator masked, reverse mode reports good regulation
        if (reverse_s && !option_reg[CHO_BIT_REVERSE_GOOD]) begin
            good_next = 1'b1; // R7
        end else begin
            good_next = good_raw_s;
        end
        // sticky until the host writes the current setting again
        expired_next = expired_reg;
        if (cur_write) begin
            expired_next = 1'b0;
        end
        if (wdt_expire && !cur_write) begin
            expired_next = 1'b1; // R4
        end
    end

    // **************************************************
    // registers
    // **************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            option_reg <= CHO_OPTION_RESET; // R10
            current_reg <= CHO_CURRENT_RESET;
            rdata_reg <= 8'h00;
            lp_reg <= 1'b0;
            loop_off_reg <= 1'b0;
            good_reg <= 1'b0;
            expired_reg <= 1'b0;
        end else if (clk_en) begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            option_reg <= option_next;
            current_reg <= current_next;
            rdata_reg <= rdata_next;
            lp_reg <= lp_next;
            loop_off_reg <= loop_off_next;
            good_reg <= good_next;
            expired_reg <= expired_next;
        end
    end

    // **************************************************
    // outputs
    // **************************************************
    assign reg_rdata = rdata_reg;
    assign low_power_active = lp_reg; // R1
    // the comparator is not touched here: it keeps its own enable
    assign gate_drive_supply_off = lp_reg; // R2
    assign adc_off = lp_reg; // R2
    assign input_current_loop_off = loop_off_reg;
    assign power_good_indicator = good_reg;
    assign ultrasonic_pfm_enable = option_reg[CHO_BIT_ULTRASONIC]; // R8
    assign switching_frequency_select = option_reg[CHO_BIT_FREQ]; // R8
    assign passthrough_low_ripple = option_reg[CHO_BIT_LOW_RIPPLE]; // R9
    assign charge_current_setting = current_reg;
    assign watchdog_expired = expired_reg;

    // **************************************************
    // assertions
    // **************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_option_reset_value: assert property ( // R10
        $rose(rst_b) |-> option_reg == CHO_OPTION_RESET)
        else $error("option byte reset value wrong");
    a_option_write_back: assert property ( // R12
        clk_en && wr_option ##1 clk_en && reg_rd
        && reg_addr == CHO_ADDR_OPTION_UPPER && !wr_option
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("option byte read back wrong");
    a_low_power_entry: assert property ( // R2
        clk_en && option_reg[CHO_BIT_LOW_POWER] && batt_only_s
        |=> gate_drive_supply_off && adc_off)
        else $error("low power mode not entered");
    a_perf_mode_stays: assert property ( // R1
        clk_en && !option_reg[CHO_BIT_LOW_POWER] |=> !low_power_active)
        else $error("low power active in performance mode");
    a_wdt_clears_cur: assert property ( // R4
        wdt_expire && !cur_write |=> charge_current_setting == 7'h00)
        else $error("watchdog expiry did not clear current");
    a_cur_high_map: assert property ( // R11
        clk_en && wr_cur_high
        |=> charge_current_setting[6:2] == $past(reg_wdata[4:0]))
        else $error("current high byte mapped wrong");
    a_loop_auto_off: assert property ( // R6
        clk_en && !option_reg[CHO_BIT_LOOP_AUTO_OFF]
        |=> !input_current_loop_off)
        else $error("input loop turned off while auto off clear");
    a_reverse_good_held: assert property ( // R7
        clk_en && reverse_s && !option_reg[CHO_BIT_REVERSE_GOOD]
        |=> power_good_indicator)
        else $error("good indicator not held in reverse mode");
    a_freq_from_option: assert property ( // R8
        clk_en && wr_option
        |=> switching_frequency_select == $past(reg_wdata[CHO_BIT_FREQ])
        && ultrasonic_pfm_enable == $past(reg_wdata[CHO_BIT_ULTRASONIC]))
        else $error("frequency options do not follow register");
    a_ripple_from_option: assert property ( // R9
        clk_en && wr_option |=> passthrough_low_ripple == $past(reg_wdata[0]))
        else $error("low ripple enable not updated");

    c_option_written: cover property (clk_en && wr_option);
    c_low_power_entered: cover property ($rose(low_power_active));
    c_wdt_clear_seen: cover property ($rose(watchdog_expired));
    c_cell_loop_off: cover property ($rose(input_current_loop_off));
endmodule : cho_option_upper

// file: rtl/cho_pkg.sv
package cho_pkg;
    // **************************************************
    // clock and watchdog timing
    // **************************************************
    localparam longint CHO_CLK_HZ = 100000000;
    localparam longint CHO_WDT_SHORT_S = 5;
    localparam longint CHO_WDT_MID_S = 88;
    localparam longint CHO_WDT_LONG_S = 175;
    localparam int CHO_WDT_CNT_W = 36;

    // **************************************************
    // register addresses
    // **************************************************
    localparam logic [7:0] CHO_ADDR_OPTION_UPPER = 8'h01;
    localparam logic [7:0] CHO_ADDR_CURRENT_LOW = 8'h02;
    localparam logic [7:0] CHO_ADDR_CURRENT_HIGH = 8'h03;

    // **************************************************
    // option byte layout and reset value
    // **************************************************
    localparam logic [7:0] CHO_OPTION_RESET = 8'he7;
    localparam int CHO_BIT_LOW_POWER = 7;
    localparam int CHO_BIT_TIMEOUT_HI = 6;
    localparam int CHO_BIT_TIMEOUT_LO = 5;
    localparam int CHO_BIT_LOOP_AUTO_OFF = 4;
    localparam int CHO_BIT_REVERSE_GOOD = 3;
    localparam int CHO_BIT_ULTRASONIC = 2;
    localparam int CHO_BIT_FREQ = 1;
    localparam int CHO_BIT_LOW_RIPPLE = 0;

    // **************************************************
    // charge current layout: high byte bits 4:0, low byte bits 7:6
    // **************************************************
    localparam logic [6:0] CHO_CURRENT_RESET = 7'h00;
    localparam int CHO_CUR_HIGH_MSB = 4;
    localparam int CHO_CUR_LOW_LSB = 6;

    typedef enum logic [1:0] {
        CHO_WDT_OFF,
        CHO_WDT_SHORT,
        CHO_WDT_MID,
        CHO_WDT_LONG
    } cho_timeout_t;
endpackage : cho_pkg

// file: rtl/cho_watchdog.sv
module cho_watchdog
    import cho_pkg::*;
#(
    parameter longint SHORT_CYC = 500000000,
    parameter longint MID_CYC = 8800000000,
    parameter longint LONG_CYC = 17500000000
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire cho_pkg::cho_timeout_t timeout_select,
    input wire logic restart,
    output logic expire
);
    logic [CHO_WDT_CNT_W-1:0] cnt_reg, cnt_next;
    logic [CHO_WDT_CNT_W-1:0] limit;
    cho_timeout_t sel_reg, sel_next;

    always_comb begin
        unique case (sel_reg)
            CHO_WDT_OFF: limit = '0;
            CHO_WDT_SHORT: limit = CHO_WDT_CNT_W'(SHORT_CYC - 1);
            CHO_WDT_MID: limit = CHO_WDT_CNT_W'(MID_CYC - 1);
            CHO_WDT_LONG: limit = CHO_WDT_CNT_W'(LONG_CYC - 1);
        endcase
        expire = clk_en && (sel_reg != CHO_WDT_OFF) && (cnt_reg == limit);
        sel_next = timeout_select;
        // a new period setting starts a fresh count
        if (restart || sel_reg == CHO_WDT_OFF || timeout_select != sel_reg
            || expire) begin // R5
            cnt_next = '0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            sel_reg <= CHO_WDT_LONG;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_wdt_off_silent: assert property ( // R3
        clk_en && sel_reg == CHO_WDT_OFF |=> cnt_reg == 0)
        else $error("watchdog counted while disabled");
    a_wdt_restart_zero: assert property (clk_en && restart |=> cnt_reg == 0) // R5
        else $error("watchdog count not restarted");
    c_wdt_expire: cover property (expire);
endmodule : cho_watchdog

// file: test/cho_host_model.sv
// ************************************************
// host side of the register port
// ************************************************
module cho_host_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle strobe; a gap cycle always follows, so no double assignment
    // pin_case option bytes write bits 6-5 as 00 to switch the timer off; the main sequence refreshes charge current in time to keep it quiet
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // data is registered, so it is taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : cho_host_model

// file: test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import cho_pkg::*;

    // ************************************************
    // clock, reset, pins
    // ************************************************
    logic sys_clk, rst_b, clk_en, bo, cr, rm, pg;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, lp, gd, ao, ilo, pgi, pfm, frq, rip, wdx;
    logic [6:0] cur;
    int mismatches = 0;
    int checks = 0;
    int cnt;

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    cho_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // short periods keep the timer tests brief
    cho_option_upper #(.WDT_SHORT_CYC(20), .WDT_MID_CYC(40),
        .WDT_LONG_CYC(60)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .battery_only_pin(bo), .cell_removed_pin(cr),
        .reverse_mode_pin(rm), .power_good_raw_pin(pg),
        .low_power_active(lp), .gate_drive_supply_off(gd), .adc_off(ao),
        .input_current_loop_off(ilo), .power_good_indicator(pgi),
        .ultrasonic_pfm_enable(pfm), .switching_frequency_select(frq),
        .passthrough_low_ripple(rip), .charge_current_setting(cur),
        .watchdog_expired(wdx));

    // ************************************************
    // checking and verdict
    // ************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // pins change after the write; 6 edges covers sync plus output flop
    task automatic pin_case(input logic [7:0] opt, input logic [3:0] p);
        host.wr(CHO_ADDR_OPTION_UPPER, opt);
        bo <= p[3];
        cr <= p[2];
        rm <= p[1];
        pg <= p[0];
        repeat (6) @(posedge sys_clk);
        #1;
        check(lp, opt[7] & p[3]);
        check(gd, opt[7] & p[3]);
        check(ao, opt[7] & p[3]);
        check(ilo, opt[4] & p[2]);
        check(pgi, (p[1] & ~opt[3]) | p[0]);
        check(pfm, opt[2]);
        check(frq, opt[1]);
        check(rip, opt[0]);
        host.rd(CHO_ADDR_OPTION_UPPER, d);
        check(d, opt);
    endtask : pin_case

    // n is the period in cycles, or the wait limit when the timer is off;
    // the count runs from the last current write
    task automatic wdt_case(input logic [1:0] sel, input int n);
        host.wr(CHO_ADDR_OPTION_UPPER, {1'b0, sel, 5'h00});
        host.wr(CHO_ADDR_CURRENT_HIGH, 8'h1f);
        host.wr(CHO_ADDR_CURRENT_LOW, 8'hc0);
        #1;
        cnt = 0;
        while (wdx !== 1'b1 && cnt < 300) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        check(wdx, sel != 2'b00);
        check(cnt == n, 1'b1);
        check(cur, (sel == 2'b00) ? 7'h7f : 7'h00);
    endtask : wdt_case

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        {bo, cr, rm, pg} = 4'h0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        check(pfm, 1'b1);
        check(frq, 1'b1);
        check(rip, 1'b1);
        host.rd(CHO_ADDR_OPTION_UPPER, d);
        check(d, 8'he7);
        host.rd(CHO_ADDR_CURRENT_LOW, d);
        check(d, 8'h00);
        // a disabled clock must swallow the strobe
        clk_en <= 1'b0;
        host.wr(CHO_ADDR_OPTION_UPPER, 8'h00);
        clk_en <= 1'b1;
        host.wr(8'h05, 8'h00);
        host.rd(CHO_ADDR_OPTION_UPPER, d);
        check(d, 8'he7);
        host.rd(8'h05, d);
        check(d, 8'h00);
        host.wr(CHO_ADDR_CURRENT_HIGH, 8'hff);
        host.wr(CHO_ADDR_CURRENT_LOW, 8'hff);
        host.rd(CHO_ADDR_CURRENT_HIGH, d);
        check(d, 8'h1f);
        host.rd(CHO_ADDR_CURRENT_LOW, d);
        check(d, 8'hc0);
        check(cur, 7'h7f);
        for (int i = 0; i < 16; i++) begin
            pin_case(8'h97, 4'(i));
            pin_case(8'h08, 4'(i));
        end
        wdt_case(2'b00, 300);
        wdt_case(2'b01, 20);
        wdt_case(2'b10, 40);
        wdt_case(2'b11, 60);
        // steady refresh inside the short period keeps the setting
        host.wr(CHO_ADDR_OPTION_UPPER, 8'h20);
        host.wr(CHO_ADDR_CURRENT_HIGH, 8'h01);
        repeat (6) begin
            host.wr(CHO_ADDR_CURRENT_LOW, 8'h40);
            repeat (10) @(posedge sys_clk);
        end
        #1;
        check(wdx, 1'b0);
        check(cur, 7'h05);
        print_verdict();
    end

    initial begin
        #200us;
        mismatches++;
        print_verdict();
    end
endmodule : testbench
